//--- hdl/sspc_pkg.sv
// package: register map, fields, mode codes and timing for the serial port control block
package sspc_pkg;
    localparam logic [11:0] SSPC_CTRL_OFS     = 12'h000;
    localparam logic [11:0] SSPC_BUF_OFS      = 12'h004;
    localparam logic [11:0] SSPC_BAUD_OFS     = 12'h008;
    localparam logic [11:0] SSPC_STAT_OFS     = 12'h00C;
    localparam logic [11:0] SSPC_EVT_OFS      = 12'h010;
    localparam logic [7:0]  SSPC_CTRL_RST     = 8'h00;
    localparam int          SSPC_WRITE_COLLISION_FLAG_BIT     = 7;
    localparam int          SSPC_OV_BIT       = 6;
    localparam int          SSPC_EN_BIT       = 5;
    localparam int          SSPC_CKP_BIT      = 4;
    localparam logic [3:0]  SSPC_M_SPI_D4     = 4'h0;
    localparam logic [3:0]  SSPC_M_SPI_D16    = 4'h1;
    localparam logic [3:0]  SSPC_M_SPI_D64    = 4'h2;
    localparam logic [3:0]  SSPC_M_SPI_TMR    = 4'h3;
    localparam logic [3:0]  SSPC_M_SPI_SL_SS  = 4'h4;
    localparam logic [3:0]  SSPC_M_SPI_SL     = 4'h5;
    localparam logic [3:0]  SSPC_M_TW_SL7     = 4'h6;
    localparam logic [3:0]  SSPC_M_TW_SL10    = 4'h7;
    localparam logic [3:0]  SSPC_M_TW_MST     = 4'h8;
    localparam logic [3:0]  SSPC_M_SPI_BAUD   = 4'hA;
    localparam logic [3:0]  SSPC_M_TW_FW      = 4'hB;
    localparam logic [3:0]  SSPC_M_TW_SL7I    = 4'hE;
    localparam logic [3:0]  SSPC_M_TW_SL10I   = 4'hF;
    localparam logic [7:0]  SSPC_DIV4_M1      = 8'h01;
    localparam logic [7:0]  SSPC_DIV16_M1     = 8'h07;
    localparam logic [7:0]  SSPC_DIV64_M1     = 8'h1F;
    localparam logic [2:0]  SSPC_BITS_M1      = 3'h7;
    localparam logic [1:0]  SSPC_HTRANS_NSEQ  = 2'h2;
    localparam logic [2:0]  SSPC_HSIZE_WORD   = 3'h2;
    typedef enum logic [1:0] {SSPC_FAM_SPI_M, SSPC_FAM_SPI_S,
                              SSPC_FAM_TW_M, SSPC_FAM_TW_S} sspc_fam_t;
endpackage : sspc_pkg

//--- hdl/sspc_bus_if.sv
// interface: decoded register access between bus slave and shifter core
`timescale 1ns/10ps
interface sspc_bus_if;
    logic        wr;
    logic        rd;
    logic [11:0] ofs;
    logic [7:0]  wdata;
    logic [31:0] rdata;
    modport master (output wr, output rd, output ofs, output wdata, input rdata);
    modport slave  (input wr, input rd, input ofs, input wdata, output rdata);
endinterface : sspc_bus_if

//--- hdl/sspc_ahb_slave.sv
// AHB-Lite slave front end: captures address phase, issues one-cycle strobes
`timescale 1ns/10ps
module sspc_ahb_slave
    import sspc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    sspc_bus_if.master       rb
);
    logic        wpend_ff;
    logic        rpend_ff;
    logic [11:0] aofs_ff;
    logic        take;

    assign take = hsel && hready && htrans == SSPC_HTRANS_NSEQ && hsize == SSPC_HSIZE_WORD;

    always_ff @(posedge mclk) begin
        if (rst) begin
            wpend_ff <= 1'b0;
            rpend_ff <= 1'b0;
            aofs_ff  <= 12'h000;
        end else begin
            wpend_ff <= take && hwrite;
            rpend_ff <= take && !hwrite;
            if (take) begin
                aofs_ff <= haddr[11:0];
            end
        end
    end

    assign rb.wr    = wpend_ff;
    assign rb.rd    = rpend_ff;
    assign rb.ofs   = aofs_ff;
    assign rb.wdata = hwdata[7:0];

    // one wait state on reads, so hrdata is registered before hready rises
    always_ff @(posedge mclk) begin
        if (rst) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b0;
        end else begin
            hreadyout <= !(take && !hwrite);
            if (rpend_ff) begin
                hrdata <= rb.rdata;
            end
        end
    end
endmodule : sspc_ahb_slave

//--- hdl/sspc_top.sv
// serial port control: mode decode, flags, pin routing and byte shifter
// Operation
// - master: buffer write while two-wire bus busy sets write collision
// - slave: buffer write while a loaded byte is still shifting (busy) sets write collision
// - SPI overflow only in slave mode when unread byte present
// - on SPI overflow new byte dropped, old buffer kept
// - SPI master never sets overflow
// - two-wire slave receive with unread byte sets overflow, ignored in transmit
// - enable in SPI routes clock, data out, data in, select pins
// - enable in two-wire routes data and clock pins
// - SPI clock idle level follows polarity bit
// - two-wire slave: polarity one releases clock, zero stretches
// - codes 0-2 divide by 4,16,64; code 3 uses timer two half
// - codes 4,5 SPI slave with select enabled or disabled
// - codes 6,7 two-wire slave 7/10-bit without start/stop events
// - codes E,F two-wire slave with start and stop events
// - code A clock is osc over four times baud plus one; code 8 drives no clock
// - code B firmware master, slave idle
`timescale 1ns/10ps
module sspc_top
    import sspc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    input  wire logic        timer_two_out,
    input  wire logic        serial_clock_pin_in,
    output logic             serial_clock_pin_out,
    output logic             serial_clock_pin_oe,
    output logic             serial_data_out_pin,
    output logic             serial_data_out_pin_oe,
    input  wire logic        serial_data_in_pin,
    input  wire logic        slave_select_pin_n,
    input  wire logic        two_wire_data_pin_in,
    input  wire logic        two_wire_clock_pin_in,
    output logic             two_wire_clock_pin_oe,
    input  wire logic        two_wire_busy,
    input  wire logic        two_wire_start,
    input  wire logic        two_wire_stop,
    output logic             start_stop_event,
    output logic             pins_to_port
);
    sspc_bus_if rb ();

    sspc_ahb_slave u_bus (
        .mclk      (mclk),
        .rst       (rst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .hwdata    (hwdata),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .rb        (rb)
    );

    logic [7:0] ctrl_ff;
    logic [7:0] buf_ff;
    logic [7:0] baud_ff;
    logic [7:0] sr_ff;
    logic [2:0] bitcnt_ff;
    logic       busy_ff;
    logic       full_ff;
    logic [8:0] divcnt_ff;
    logic       tmr_d_ff;
    logic       tmr_half_ff;
    logic       sck_int_ff;
    logic       sclk_d_ff;
    logic       twclk_d_ff;
    logic [3:0] mode;
    logic       en;
    logic       clock_polarity_bit;
    sspc_fam_t  fam;
    logic       buf_wr;
    logic       buf_rd;
    logic       tick;
    logic       shift_edge;
    logic       sample_edge;
    logic       byte_done;
    logic       set_write_collision_flag;
    logic       set_ov;
    logic       ss_used;
    logic [8:0] div_m1;

    // mode family decode, used by routing, flags and clocking
    function automatic sspc_fam_t fam_of(input logic [3:0] m);
        case (m)
            SSPC_M_SPI_D4, SSPC_M_SPI_D16, SSPC_M_SPI_D64,
            SSPC_M_SPI_TMR, SSPC_M_SPI_BAUD: fam_of = SSPC_FAM_SPI_M;
            SSPC_M_SPI_SL_SS, SSPC_M_SPI_SL:   fam_of = SSPC_FAM_SPI_S;
            SSPC_M_TW_MST, SSPC_M_TW_FW:       fam_of = SSPC_FAM_TW_M;
            default:                           fam_of = SSPC_FAM_TW_S;
        endcase
    endfunction : fam_of

    assign mode    = ctrl_ff[3:0];
    assign en      = ctrl_ff[SSPC_EN_BIT];
    assign clock_polarity_bit     = ctrl_ff[SSPC_CKP_BIT];
    assign fam     = fam_of(mode);
    assign ss_used = mode == SSPC_M_SPI_SL_SS;
    assign buf_wr  = rb.wr && rb.ofs == SSPC_BUF_OFS;
    assign buf_rd  = rb.rd && rb.ofs == SSPC_BUF_OFS;

    // master clock divider selection
    always_comb begin
        case (mode)
            SSPC_M_SPI_D4:  div_m1 = {1'b0, SSPC_DIV4_M1};
            SSPC_M_SPI_D16: div_m1 = {1'b0, SSPC_DIV16_M1};
            SSPC_M_SPI_D64: div_m1 = {1'b0, SSPC_DIV64_M1};
            default:        div_m1 = {baud_ff, 1'b1};
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            divcnt_ff   <= 9'h000;
            tmr_d_ff    <= 1'b0;
            tmr_half_ff <= 1'b0;
        end else begin
            tmr_d_ff <= timer_two_out;
            if (busy_ff && mode != SSPC_M_SPI_TMR && divcnt_ff != div_m1) begin
                divcnt_ff <= divcnt_ff + 9'h001;
            end else begin
                divcnt_ff <= 9'h000;
            end
            if (timer_two_out && !tmr_d_ff) begin
                tmr_half_ff <= !tmr_half_ff;
            end
        end
    end

    // one-cycle half-period tick for master shifting
    assign tick = busy_ff && (mode == SSPC_M_SPI_TMR ? (timer_two_out && !tmr_d_ff)
                                                      : divcnt_ff == div_m1);

    always_ff @(posedge mclk) begin
        if (rst) begin
            sclk_d_ff  <= 1'b0;
            twclk_d_ff <= 1'b1;
        end else begin
            sclk_d_ff  <= serial_clock_pin_in;
            twclk_d_ff <= two_wire_clock_pin_in;
        end
    end

    // leading edge leaves idle level, trailing edge returns to it
    always_comb begin
        sample_edge = 1'b0;
        shift_edge  = 1'b0;
        case (fam)
            SSPC_FAM_SPI_M: begin
                sample_edge = tick && (sck_int_ff == clock_polarity_bit);
                shift_edge  = tick && (sck_int_ff != clock_polarity_bit);
            end
            SSPC_FAM_SPI_S: begin
                sample_edge = (serial_clock_pin_in != sclk_d_ff) && (sclk_d_ff == clock_polarity_bit)
                              && !(ss_used && slave_select_pin_n);
                shift_edge  = (serial_clock_pin_in != sclk_d_ff) && (sclk_d_ff != clock_polarity_bit)
                              && !(ss_used && slave_select_pin_n);
            end
            default: begin
                sample_edge = two_wire_clock_pin_in && !twclk_d_ff && mode != SSPC_M_TW_FW;
            end
        endcase
    end

    assign byte_done = en && sample_edge && bitcnt_ff == SSPC_BITS_M1;

    always_ff @(posedge mclk) begin
        if (rst) begin
            sr_ff     <= 8'h00;
            bitcnt_ff <= 3'h0;
            busy_ff   <= 1'b0;
            sck_int_ff <= 1'b0;
        end else begin
            if (!en || fam != SSPC_FAM_SPI_M || !busy_ff) begin
                sck_int_ff <= clock_polarity_bit;
            end else if (tick) begin
                sck_int_ff <= !sck_int_ff;
            end
            if (!en) begin
                busy_ff   <= 1'b0;
                bitcnt_ff <= 3'h0;
            end else if (buf_wr && !busy_ff && !(fam == SSPC_FAM_TW_M && two_wire_busy)) begin
                sr_ff     <= rb.wdata;
                busy_ff   <= 1'b1;
                bitcnt_ff <= 3'h0;
            end else if (sample_edge) begin
                sr_ff     <= {sr_ff[6:0], fam[1] ? two_wire_data_pin_in : serial_data_in_pin};
                bitcnt_ff <= bitcnt_ff + 3'h1;
                if (bitcnt_ff == SSPC_BITS_M1 && fam != SSPC_FAM_SPI_M) begin
                    busy_ff <= 1'b0;
                end
            end else if (fam == SSPC_FAM_SPI_M && shift_edge && bitcnt_ff == 3'h0) begin
                busy_ff <= 1'b0;
            end
        end
    end

    // receive buffer: overflow keeps old contents
    always_ff @(posedge mclk) begin
        if (rst) begin
            buf_ff  <= 8'h00;
            full_ff <= 1'b0;
        end else begin
            if (byte_done && !full_ff) begin
                buf_ff  <= {sr_ff[6:0], fam[1] ? two_wire_data_pin_in : serial_data_in_pin};
                full_ff <= 1'b1;
            end else if (buf_rd) begin
                full_ff <= 1'b0;
            end
        end
    end

    assign set_write_collision_flag = buf_wr && en &&
                      ((fam[0] == 1'b0 && fam == SSPC_FAM_TW_M && two_wire_busy)
                       || (fam[0] && busy_ff));
    assign set_ov   = byte_done && full_ff &&
                      (fam == SSPC_FAM_SPI_S
                       || (fam == SSPC_FAM_TW_S && !busy_ff));

    // control register; hardware set beats software clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_ff <= SSPC_CTRL_RST;
            baud_ff <= 8'h00;
        end else begin
            if (rb.wr && rb.ofs == SSPC_CTRL_OFS) begin
                ctrl_ff[5:0] <= rb.wdata[5:0];
                if (!rb.wdata[SSPC_WRITE_COLLISION_FLAG_BIT]) begin
                    ctrl_ff[SSPC_WRITE_COLLISION_FLAG_BIT] <= 1'b0;
                end
                if (!rb.wdata[SSPC_OV_BIT]) begin
                    ctrl_ff[SSPC_OV_BIT] <= 1'b0;
                end
            end
            if (set_write_collision_flag) begin
                ctrl_ff[SSPC_WRITE_COLLISION_FLAG_BIT] <= 1'b1;
            end
            if (set_ov) begin
                ctrl_ff[SSPC_OV_BIT] <= 1'b1;
            end
            if (rb.wr && rb.ofs == SSPC_BAUD_OFS) begin
                baud_ff <= rb.wdata;
            end
        end
    end

    always_comb begin
        case (rb.ofs)
            SSPC_CTRL_OFS: rb.rdata = {24'h000000, ctrl_ff};
            SSPC_BUF_OFS:  rb.rdata = {24'h000000, buf_ff};
            SSPC_BAUD_OFS: rb.rdata = {24'h000000, baud_ff};
            SSPC_STAT_OFS: rb.rdata = {29'h00000000, tmr_half_ff, full_ff, busy_ff};
            default:       rb.rdata = 32'h0000_0000;
        endcase
    end

    // pin routing, all outputs registered
    always_ff @(posedge mclk) begin
        if (rst) begin
            serial_clock_pin_out   <= 1'b0;
            serial_clock_pin_oe    <= 1'b0;
            serial_data_out_pin    <= 1'b0;
            serial_data_out_pin_oe <= 1'b0;
            two_wire_clock_pin_oe  <= 1'b0;
            start_stop_event       <= 1'b0;
            pins_to_port           <= 1'b0;
        end else begin
            pins_to_port           <= en;
            serial_clock_pin_out   <= fam == SSPC_FAM_SPI_M ? sck_int_ff : clock_polarity_bit;
            serial_clock_pin_oe    <= en && fam == SSPC_FAM_SPI_M;
            serial_data_out_pin    <= sr_ff[7];
            serial_data_out_pin_oe <= en && !fam[1] &&
                                      !(ss_used && slave_select_pin_n);
            two_wire_clock_pin_oe  <= en && fam == SSPC_FAM_TW_S && !clock_polarity_bit;
            start_stop_event       <= en && (mode == SSPC_M_TW_SL7I || mode == SSPC_M_TW_SL10I)
                                      && (two_wire_start || two_wire_stop);
        end
    end

    property p_ov_never_spi_master;
        @(posedge mclk) disable iff (rst)
        fam == SSPC_FAM_SPI_M && !ctrl_ff[SSPC_OV_BIT] |=> !ctrl_ff[SSPC_OV_BIT];
    endproperty
    a_ov_never_spi_master: assert property (p_ov_never_spi_master)
        else $error("overflow set in spi master");

    property p_write_collision_flag_slave;
        @(posedge mclk) disable iff (rst)
        fam == SSPC_FAM_SPI_S && en && buf_wr && busy_ff |=> ctrl_ff[SSPC_WRITE_COLLISION_FLAG_BIT];
    endproperty
    a_write_collision_flag_slave: assert property (p_write_collision_flag_slave)
        else $error("slave collision not flagged");

    property p_ov_keeps_buf;
        @(posedge mclk) disable iff (rst)
        set_ov |=> ctrl_ff[SSPC_OV_BIT] && buf_ff == $past(buf_ff);
    endproperty
    a_ov_keeps_buf: assert property (p_ov_keeps_buf)
        else $error("overflow lost old buffer");

    property p_flag_sticky;
        @(posedge mclk) disable iff (rst)
        ctrl_ff[SSPC_WRITE_COLLISION_FLAG_BIT] && !(rb.wr && rb.ofs == SSPC_CTRL_OFS && !rb.wdata[7])
        |=> ctrl_ff[SSPC_WRITE_COLLISION_FLAG_BIT];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("collision flag dropped");

    property p_idle_level;
        @(posedge mclk) disable iff (rst)
        !en ##1 !en && $stable(clock_polarity_bit) |=> serial_clock_pin_out == $past(clock_polarity_bit, 2);
    endproperty
    a_idle_level: assert property (p_idle_level)
        else $error("idle clock level wrong");

    property p_route;
        @(posedge mclk) disable iff (rst)
        !en |=> !pins_to_port && !serial_clock_pin_oe && !serial_data_out_pin_oe;
    endproperty
    a_route: assert property (p_route)
        else $error("pins driven while disabled");

    property p_stretch;
        @(posedge mclk) disable iff (rst)
        en && fam == SSPC_FAM_TW_S && !clock_polarity_bit |=> two_wire_clock_pin_oe;
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("clock not stretched");

    property p_no_ss_event;
        @(posedge mclk) disable iff (rst)
        mode == SSPC_M_TW_SL7 || mode == SSPC_M_TW_SL10 |=> !start_stop_event;
    endproperty
    a_no_ss_event: assert property (p_no_ss_event)
        else $error("start/stop event in plain slave mode");
endmodule : sspc_top

//--- sim/sspc_peer.sv
// far-side SPI master model: frames one byte per go request, msb first
`timescale 1ns/10ps
module sspc_peer (
    input  wire logic       mclk,
    input  wire logic       go,
    input  wire logic       cpol,
    input  wire logic [7:0] tx_byte,
    output logic            sclk,
    output logic            sdi,
    output logic            ss_n,
    output logic            busy
);
    initial begin
        sclk = 1'b0;
        sdi  = 1'b0;
        ss_n = 1'b1;
        busy = 1'b0;
    end
    always begin
        @(posedge mclk);
        if (go === 1'b1) begin
            busy <= 1'b1;
            ss_n <= 1'b0;
            for (int i = 7; i >= 0; i--) begin
                // data settles well before and after both clock edges
                sdi <= tx_byte[i];
                repeat (4) @(posedge mclk);
                sclk <= ~cpol;
                repeat (8) @(posedge mclk);
                sclk <= cpol;
                repeat (4) @(posedge mclk);
            end
            ss_n <= 1'b1;
            busy <= 1'b0;
        end else begin
            // clock stands at idle; unselected data line never holds a value
            sclk <= cpol;
            sdi  <= ~sdi;
        end
    end
endmodule : sspc_peer

//--- sim/test_sync_serial_port_control.sv
// testbench: register-level tests of the serial port control block
`timescale 1ns/10ps
module test_sync_serial_port_control
    import sspc_pkg::*;
;
    localparam int TPER = 6;
    localparam int BAUD = 3;
    logic        mclk, rst, hsel, hwrite, hready, hreadyout, timer_two_out;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        sck_out, sck_oe, sdo, sdo_oe, tw_clk_oe, tw_busy, tw_start, tw_stop;
    logic        evt, pins_to_port, peer_go, peer_sclk, peer_sdi, peer_ss_n, peer_busy;
    logic [7:0]  peer_byte;
    int          tcnt, mismatches, n_checks, n;
    logic [3:0]  mc [5] = '{SSPC_M_SPI_D4, SSPC_M_SPI_D16, SSPC_M_SPI_D64,
                            SSPC_M_SPI_TMR, SSPC_M_SPI_BAUD};
    int          hx [5] = '{4 / 2, 16 / 2, 64 / 2, TPER, 4 * (BAUD + 1) / 2};
    logic [3:0]  tc [5] = '{SSPC_M_TW_SL7, SSPC_M_TW_SL10, SSPC_M_TW_SL7I,
                            SSPC_M_TW_SL10I, SSPC_M_TW_FW};
    int          tx [5] = '{0, 0, 2, 2, 0};

    assign hready = hreadyout;

    sspc_top sspc_top_i (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
        .hreadyout(hreadyout), .hrdata(hrdata), .timer_two_out(timer_two_out),
        .serial_clock_pin_in(peer_sclk), .serial_clock_pin_out(sck_out),
        .serial_clock_pin_oe(sck_oe), .serial_data_out_pin(sdo),
        .serial_data_out_pin_oe(sdo_oe), .serial_data_in_pin(peer_sdi),
        .slave_select_pin_n(peer_ss_n), .two_wire_data_pin_in(1'b1),
        .two_wire_clock_pin_in(~tw_clk_oe), .two_wire_clock_pin_oe(tw_clk_oe),
        .two_wire_busy(tw_busy), .two_wire_start(tw_start), .two_wire_stop(tw_stop),
        .start_stop_event(evt), .pins_to_port(pins_to_port));

    sspc_peer sspc_peer_i (.mclk(mclk), .go(peer_go), .cpol(1'b0), .tx_byte(peer_byte),
        .sclk(peer_sclk), .sdi(peer_sdi), .ss_n(peer_ss_n), .busy(peer_busy));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        tcnt <= (tcnt == TPER - 1) ? 0 : tcnt + 1;
        timer_two_out <= (tcnt == 0);
    end

    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_up(input string what);
        mismatches++;
        $display("mismatch %s expected done seen timeout", what);
        end_of_test();
    endtask : give_up

    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int k;
        hsel   <= 1'b1;
        haddr  <= {20'h00000, a};
        htrans <= SSPC_HTRANS_NSEQ;
        hwrite <= wr;
        k = 0;
        do begin @(posedge mclk); k++; end while (hreadyout !== 1'b1 && k < 50);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge mclk); k++; end while (hreadyout !== 1'b1 && k < 100);
        if (k >= 100) give_up("bus ready");
        rd = hrdata;
    endtask : ahb

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] dummy;
        ahb(1'b1, a, v, dummy);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        ahb(1'b0, a, 32'h00000000, v);
    endtask : rd

    function automatic logic [31:0] ctl(input logic en, input logic cp, input logic [3:0] m);
        return {24'h000000, 2'b00, en, cp, m};
    endfunction : ctl

    task automatic half(output int h);
        int k;
        logic last;
        for (int t = 0; t < 2; t++) begin
            last = sck_out;
            k = 0;
            while (sck_out === last && k < 3000) begin @(posedge mclk); k++; end
            if (k >= 3000) give_up("clock toggle");
        end
        h = k;
    endtask : half

    task automatic idle_wait;
        int k;
        logic [31:0] s;
        k = 0;
        do begin rd(SSPC_STAT_OFS, s); k++; end while (s[0] !== 1'b0 && k < 400);
        if (k >= 400) give_up("transfer end");
    endtask : idle_wait

    task automatic kick(input logic [7:0] b);
        peer_byte <= b;
        peer_go   <= 1'b1;
        @(posedge mclk);
        peer_go   <= 1'b0;
    endtask : kick

    task automatic peer_wait;
        int k;
        k = 0;
        do begin @(posedge mclk); k++; end while (peer_busy !== 1'b0 && k < 1000);
        if (k >= 1000) give_up("peer frame");
    endtask : peer_wait

    task automatic events(output int cnt);
        cnt = 0;
        for (int k = 0; k < 16; k++) begin
            tw_start <= (k == 0);
            tw_stop  <= (k == 6);
            @(posedge mclk);
            if (evt === 1'b1) cnt++;
        end
    endtask : events

    initial begin
        rst = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0; hwdata = '0;
        hsize = SSPC_HSIZE_WORD; tw_busy = 1'b0; tw_start = 1'b0; tw_stop = 1'b0;
        peer_go = 1'b0; peer_byte = 8'h00; tcnt = 0; timer_two_out = 1'b0;
        mismatches = 0; n_checks = 0;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        rd(SSPC_CTRL_OFS, d); check("ctrl reset", d, {24'h0, SSPC_CTRL_RST});
        wr(12'h020, 32'h000000FF);
        rd(12'h020, d); check("unmapped", d, 32'h0);
        wr(SSPC_CTRL_OFS, 32'h000000C0);
        rd(SSPC_CTRL_OFS, d); check("flags by write", d, 32'h0);
        for (int c = 0; c < 2; c++) begin
            wr(SSPC_CTRL_OFS, ctl(1'b1, c[0], SSPC_M_SPI_D4));
            repeat (4) @(posedge mclk);
            check("clock idle", {31'h0, sck_out}, {31'h0, c[0]});
            check("routing", {29'h0, pins_to_port, sck_oe, sdo_oe}, 32'h7);
        end
        wr(SSPC_CTRL_OFS, 32'h0);
        repeat (4) @(posedge mclk);
        check("released", {31'h0, pins_to_port}, 32'h0);
        wr(SSPC_BAUD_OFS, BAUD);
        for (int k = 0; k < 5; k++) begin
            wr(SSPC_CTRL_OFS, ctl(1'b1, 1'b0, mc[k]));
            wr(SSPC_BUF_OFS, 32'h000000A5);
            half(n); check("clock half period", 32'(n), 32'(hx[k]));
            idle_wait();
            check("clock back at idle", {31'h0, sck_out}, 32'h0);
        end
        rd(SSPC_CTRL_OFS, d); check("master overflow", {31'h0, d[6]}, 32'h0);
        rd(SSPC_BUF_OFS, d);
        wr(SSPC_CTRL_OFS, ctl(1'b1, 1'b0, SSPC_M_SPI_SL_SS));
        repeat (4) @(posedge mclk);
        check("out enable select high", {31'h0, sdo_oe}, 32'h0);
        wr(SSPC_CTRL_OFS, ctl(1'b1, 1'b0, SSPC_M_SPI_SL));
        repeat (4) @(posedge mclk);
        check("out enable no select", {31'h0, sdo_oe}, 32'h1);
        wr(SSPC_CTRL_OFS, ctl(1'b1, 1'b0, SSPC_M_SPI_SL_SS));
        kick(8'h3C); peer_wait();
        kick(8'hC3); peer_wait();
        rd(SSPC_CTRL_OFS, d); check("slave overflow", {31'h0, d[6]}, 32'h1);
        rd(SSPC_BUF_OFS, d); check("buffer kept", d, 32'h3C);
        wr(SSPC_CTRL_OFS, 32'hC0 | ctl(1'b1, 1'b0, SSPC_M_SPI_SL_SS));
        rd(SSPC_CTRL_OFS, d); check("flags write one", {30'h0, d[7:6]}, 32'h1);
        wr(SSPC_CTRL_OFS, ctl(1'b1, 1'b0, SSPC_M_SPI_SL_SS));
        rd(SSPC_CTRL_OFS, d); check("flags cleared", d, 32'h24);
        wr(SSPC_BUF_OFS, 32'h55);
        rd(SSPC_CTRL_OFS, d); check("no collision", {31'h0, d[7]}, 32'h0);
        check("data out msb", {31'h0, sdo}, 32'h0);
        kick(8'h0F);
        repeat (20) @(posedge mclk);
        wr(SSPC_BUF_OFS, 32'h66);
        peer_wait();
        rd(SSPC_CTRL_OFS, d); check("slave collision", {31'h0, d[7]}, 32'h1);
        rd(SSPC_BUF_OFS, d);
        wr(SSPC_CTRL_OFS, ctl(1'b1, 1'b0, SSPC_M_TW_MST));
        tw_busy <= 1'b1;
        wr(SSPC_BUF_OFS, 32'h5A);
        rd(SSPC_CTRL_OFS, d); check("master collision", {31'h0, d[7]}, 32'h1);
        tw_busy <= 1'b0;
        wr(SSPC_CTRL_OFS, ctl(1'b1, 1'b0, SSPC_M_TW_MST));
        rd(SSPC_CTRL_OFS, d); check("collision cleared", {31'h0, d[7]}, 32'h0);
        for (int c = 0; c < 2; c++) begin
            wr(SSPC_CTRL_OFS, ctl(1'b1, c[0], SSPC_M_TW_SL7));
            repeat (4) @(posedge mclk);
            check("stretch", {31'h0, tw_clk_oe}, {31'h0, ~c[0]});
            check("two-wire routing", {30'h0, pins_to_port, sck_oe}, 32'h2);
        end
        // reserved codes are never programmed
        for (int k = 0; k < 5; k++) begin
            wr(SSPC_CTRL_OFS, ctl(1'b1, 1'b1, tc[k]));
            events(n); check("start stop events", 32'(n), 32'(tx[k]));
        end
        // clock line follows the stretch output: toggling polarity clocks in two bytes
        wr(SSPC_CTRL_OFS, 32'h0);
        for (int i = 0; i < 32; i++) begin
            wr(SSPC_CTRL_OFS, ctl(1'b1, i[0], SSPC_M_TW_SL7));
        end
        repeat (2) @(posedge mclk);
        rd(SSPC_CTRL_OFS, d); check("two-wire overflow", {31'h0, d[6]}, 32'h1);
        end_of_test();
    end
endmodule : test_sync_serial_port_control
